//--- sqtpm_pkg.sv
package sqtpm_pkg;

  // ****************************************
  // pad group sizes and pad indices
  // ****************************************
  localparam int QUAD_PADS = 4;
  localparam int SPI_PADS  = 3;
  localparam int SPI_SCLK  = 0;
  localparam int SPI_MOSI  = 1;
  localparam int SPI_MISO  = 2;

  // ****************************************
  // pull-up control field positions
  // ****************************************
  localparam int QUAD_PULLUP_LSB = 4;
  localparam int SPI_PULLUP_LSB  = 4;

  // ****************************************
  // function selector encodings and reset values
  // ****************************************
  localparam logic [1:0] QUAD_FUNC_DECODER = 2'h0;
  localparam logic [1:0] QUAD_FUNC_TIMER   = 2'h1;
  localparam logic [1:0] QUAD_FUNC_GPIO    = 2'h2;
  localparam logic [7:0] QUAD_SEL_RESET    = 8'h00;
  localparam logic       SPI_FUNC_PERIPH   = 1'b0;
  localparam logic       SPI_FUNC_GPIO     = 1'b1;
  localparam logic [2:0] SPI_SEL_RESET     = 3'h0;

  // ****************************************
  // test data output stream and decoder idle level
  // ****************************************
  localparam int         TDO_WORD_W     = 8;
  localparam int         TDO_FIFO_DEPTH = 8;
  localparam int         TDO_CNT_W      = 4;
  localparam logic       TDO_IDLE_BIT   = 1'b1;
  localparam logic       DEC_IDLE_LEVEL = 1'b1;

endpackage

//--- sqtpm_stream_if.sv
`timescale 1ns/100ps

// ****************************************
// valid/ready word stream between block modules
// ****************************************
interface sqtpm_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

//--- sqtpm_fifo.sv
`timescale 1ns/100ps

module sqtpm_fifo
  import sqtpm_pkg::*;
#(
  parameter int WIDTH = TDO_WORD_W,
  parameter int DEPTH = TDO_FIFO_DEPTH
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  sqtpm_stream_if.sink    wr,
  sqtpm_stream_if.source  rd
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic             ready_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [CW-1:0]    nxt_count;
  logic             nxt_ready;
  logic             push;
  logic             pop;

  // ****************************************
  // pointer and fill bookkeeping
  // ****************************************
  // ready is registered so the top can hand it out straight from a flop
  always_comb
  begin
    push       = wr.valid && ready_ff;
    pop        = rd.ready && (count_ff != '0);
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    if (push)
    begin
      nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_ff + 1'b1);
    end
    if (pop)
    begin
      nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_ff + 1'b1);
    end
    nxt_count = CW'(count_ff + CW'(push) - CW'(pop));
    nxt_ready = (nxt_count < CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ready_ff  <= 1'b0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
      ready_ff  <= nxt_ready;
    end
  end

  // storage carries no reset, only valid words are ever read
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= wr.data;
    end
  end

  assign wr.ready = ready_ff;
  assign rd.valid = (count_ff != '0);
  assign rd.data  = mem_ff[rd_ptr_ff];

endmodule

//--- sqtpm_pad_mux.sv
`timescale 1ns/100ps

// How it works
// - test output driven only in shift states
// - test output changes on test clock fall
// - decoder pads default to decoder functions
// - port C bits 4-7 gate decoder pull-ups
// - SPI pads default to SPI functions
// - port E bits 4-6 gate SPI pull-ups
// - GPIO pins have independent direction each
// - serial clock drives as master, receives as slave
// - master-out pad output as master, input slave
// - master-out data leads latching edge half cycle
// - master-in pad input as master, output slave
// - unselected slave floats its master-in pad
// - master-in data leads latching edge half cycle
module sqtpm_pad_mux
  import sqtpm_pkg::*;
#(
  parameter int WORD_W     = TDO_WORD_W,
  parameter int FIFO_DEPTH = TDO_FIFO_DEPTH
)
(
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  tck,
  input  wire logic [QUAD_PADS-1:0]  quad_pad_in,
  output wire logic [QUAD_PADS-1:0]  quad_pad_out,
  output wire logic [QUAD_PADS-1:0]  quad_pad_oe,
  output wire logic [QUAD_PADS-1:0]  quad_pad_pullup_en,
  input  wire logic [SPI_PADS-1:0]   spi_pad_in,
  output wire logic [SPI_PADS-1:0]   spi_pad_out,
  output wire logic [SPI_PADS-1:0]   spi_pad_oe,
  output wire logic [SPI_PADS-1:0]   spi_pad_pullup_en,
  input  wire logic                  spi_port0_slave_select_n,
  input  wire logic [7:0]            port_c_pullup_control,
  input  wire logic [7:0]            port_e_pullup_control,
  input  wire logic                  quad_sel_wr,
  input  wire logic [7:0]            quad_sel_data,
  output wire logic [7:0]            quad_sel_state,
  input  wire logic                  spi_sel_wr,
  input  wire logic [SPI_PADS-1:0]   spi_sel_data,
  output wire logic [SPI_PADS-1:0]   spi_sel_state,
  output wire logic                  decoder_phase_a_input,
  output wire logic                  decoder_phase_b_input,
  output wire logic                  decoder_index_input,
  output wire logic                  decoder_home_input,
  input  wire logic [QUAD_PADS-1:0]  timer_a_out,
  input  wire logic [QUAD_PADS-1:0]  timer_a_oe,
  output wire logic [QUAD_PADS-1:0]  timer_a_in,
  input  wire logic [QUAD_PADS-1:0]  gpio_c_out,
  input  wire logic [QUAD_PADS-1:0]  gpio_c_dir,
  output wire logic [QUAD_PADS-1:0]  gpio_c_in,
  input  wire logic [SPI_PADS-1:0]   gpio_e_out,
  input  wire logic [SPI_PADS-1:0]   gpio_e_dir,
  output wire logic [SPI_PADS-1:0]   gpio_e_in,
  input  wire logic                  spi_master_mode,
  input  wire logic                  spi_sclk_out,
  input  wire logic                  spi_mosi_out,
  input  wire logic                  spi_miso_out,
  output wire logic                  spi_sclk_in,
  output wire logic                  spi_mosi_in,
  output wire logic                  spi_miso_in,
  output wire logic                  spi_selected,
  input  wire logic                  tap_shift_state,
  input  wire logic                  tdo_wr_valid,
  input  wire logic [WORD_W-1:0]     tdo_wr_data,
  output wire logic                  tdo_wr_ready,
  output wire logic                  tdo_pad_out,
  output wire logic                  tdo_pad_oe
);

  localparam int NPAD = QUAD_PADS + SPI_PADS + 1;

  // decode one pad's two-bit function field
  function automatic logic [1:0] quad_func(input logic [7:0] sel, input int idx);
    logic [1:0] f;
    f = sel[2*idx +: 2];
    quad_func = f;
  endfunction

  // ****************************************
  // pad input synchronisers
  // ****************************************
  logic [NPAD-1:0] pad_s1_ff;
  logic [NPAD-1:0] pad_s2_ff;
  logic [NPAD-1:0] nxt_pad_s1;

  // pads are asynchronous to core_clk; second stage is the only reader of the first
  always_comb
  begin
    nxt_pad_s1 = {spi_port0_slave_select_n, spi_pad_in, quad_pad_in};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pad_s1_ff <= '1;
      pad_s2_ff <= '1;
    end
    else
    begin
      pad_s1_ff <= nxt_pad_s1;
      pad_s2_ff <= pad_s1_ff;
    end
  end

  // ****************************************
  // function selectors
  // ****************************************
  logic [7:0]          quad_sel_ff;
  logic [SPI_PADS-1:0] spi_sel_ff;
  logic [7:0]          nxt_quad_sel;
  logic [SPI_PADS-1:0] nxt_spi_sel;

  always_comb
  begin
    nxt_quad_sel = quad_sel_wr ? quad_sel_data : quad_sel_ff;
    nxt_spi_sel  = spi_sel_wr ? spi_sel_data : spi_sel_ff;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      quad_sel_ff <= QUAD_SEL_RESET;
      spi_sel_ff  <= SPI_SEL_RESET;
    end
    else
    begin
      quad_sel_ff <= nxt_quad_sel;
      spi_sel_ff  <= nxt_spi_sel;
    end
  end

  // ****************************************
  // pad routing
  // ****************************************
  logic [QUAD_PADS-1:0] q_out_ff, q_oe_ff, q_pu_ff, dec_ff, tmr_in_ff, gc_in_ff;
  logic [SPI_PADS-1:0]  s_out_ff, s_oe_ff, s_pu_ff, ge_in_ff;
  logic                 sclk_in_ff, mosi_in_ff, miso_in_ff, sel_ff;
  logic [QUAD_PADS-1:0] nxt_q_out, nxt_q_oe, nxt_q_pu, nxt_dec, nxt_tmr_in, nxt_gc_in;
  logic [SPI_PADS-1:0]  nxt_s_out, nxt_s_oe, nxt_s_pu, nxt_ge_in;
  logic                 nxt_sclk_in, nxt_mosi_in, nxt_miso_in, nxt_sel;
  logic                 slave_sel;

  // every output path is registered once and every input path three times, so SPI data keeps its phase to the clock
  always_comb
  begin
    nxt_q_out  = '0;
    nxt_q_oe   = '0;
    nxt_dec    = {QUAD_PADS{DEC_IDLE_LEVEL}};
    nxt_tmr_in = '0;
    nxt_gc_in  = '0;
    for (int p = 0; p < QUAD_PADS; p++)
    begin
      nxt_q_pu[p] = port_c_pullup_control[QUAD_PULLUP_LSB + p];
      case (quad_func(quad_sel_ff, p))
        QUAD_FUNC_TIMER:
        begin
          nxt_q_out[p]  = timer_a_out[p];
          nxt_q_oe[p]   = timer_a_oe[p];
          nxt_tmr_in[p] = pad_s2_ff[p];
        end
        QUAD_FUNC_GPIO:
        begin
          nxt_q_out[p] = gpio_c_out[p];
          nxt_q_oe[p]  = gpio_c_dir[p];
          nxt_gc_in[p] = pad_s2_ff[p];
        end
        default:
        begin
          nxt_dec[p] = pad_s2_ff[p];
        end
      endcase
    end

    // active-low select from the far master decides whether we answer
    slave_sel   = !pad_s2_ff[NPAD-1];
    nxt_sel     = slave_sel;
    nxt_s_out   = '0;
    nxt_s_oe    = '0;
    nxt_ge_in   = '0;
    nxt_sclk_in = 1'b0;
    nxt_mosi_in = 1'b0;
    nxt_miso_in = 1'b0;
    for (int i = 0; i < SPI_PADS; i++)
    begin
      nxt_s_pu[i] = port_e_pullup_control[SPI_PULLUP_LSB + i];
      if (spi_sel_ff[i] == SPI_FUNC_GPIO)
      begin
        nxt_s_out[i] = gpio_e_out[i];
        nxt_s_oe[i]  = gpio_e_dir[i];
        nxt_ge_in[i] = pad_s2_ff[QUAD_PADS + i];
      end
    end
    if (spi_sel_ff[SPI_SCLK] == SPI_FUNC_PERIPH)
    begin
      nxt_s_out[SPI_SCLK] = spi_sclk_out;
      nxt_s_oe[SPI_SCLK]  = spi_master_mode;
      nxt_sclk_in = spi_master_mode ? 1'b0 : pad_s2_ff[QUAD_PADS + SPI_SCLK];
    end
    if (spi_sel_ff[SPI_MOSI] == SPI_FUNC_PERIPH)
    begin
      nxt_s_out[SPI_MOSI] = spi_mosi_out;
      nxt_s_oe[SPI_MOSI]  = spi_master_mode;
      nxt_mosi_in = spi_master_mode ? 1'b0 : pad_s2_ff[QUAD_PADS + SPI_MOSI];
    end
    if (spi_sel_ff[SPI_MISO] == SPI_FUNC_PERIPH)
    begin
      nxt_s_out[SPI_MISO] = spi_miso_out;
      nxt_s_oe[SPI_MISO]  = !spi_master_mode && slave_sel;
      nxt_miso_in = spi_master_mode ? pad_s2_ff[QUAD_PADS + SPI_MISO] : 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_out_ff   <= '0;
      q_oe_ff    <= '0;
      q_pu_ff    <= '1;
      dec_ff     <= {QUAD_PADS{DEC_IDLE_LEVEL}};
      tmr_in_ff  <= '0;
      gc_in_ff   <= '0;
      s_out_ff   <= '0;
      s_oe_ff    <= '0;
      s_pu_ff    <= '1;
      ge_in_ff   <= '0;
      sclk_in_ff <= 1'b0;
      mosi_in_ff <= 1'b0;
      miso_in_ff <= 1'b0;
      sel_ff     <= 1'b0;
    end
    else
    begin
      q_out_ff   <= nxt_q_out;
      q_oe_ff    <= nxt_q_oe;
      q_pu_ff    <= nxt_q_pu;
      dec_ff     <= nxt_dec;
      tmr_in_ff  <= nxt_tmr_in;
      gc_in_ff   <= nxt_gc_in;
      s_out_ff   <= nxt_s_out;
      s_oe_ff    <= nxt_s_oe;
      s_pu_ff    <= nxt_s_pu;
      ge_in_ff   <= nxt_ge_in;
      sclk_in_ff <= nxt_sclk_in;
      mosi_in_ff <= nxt_mosi_in;
      miso_in_ff <= nxt_miso_in;
      sel_ff     <= nxt_sel;
    end
  end

  // ****************************************
  // test data buffer and core-side handover
  // ****************************************
  sqtpm_stream_if #(.WIDTH(WORD_W)) fill_if ();
  sqtpm_stream_if #(.WIDTH(WORD_W)) drain_if ();

  assign fill_if.valid = tdo_wr_valid;
  assign fill_if.data  = tdo_wr_data;

  sqtpm_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tdo_fifo (
    .clk   (core_clk),
    .rst_n (arst_n),
    .wr    (fill_if),
    .rd    (drain_if)
  );

  logic              req_tgl_ff, ack_s1_ff, ack_s2_ff;
  logic [WORD_W-1:0] hold_ff;
  logic              nxt_req_tgl;
  logic [WORD_W-1:0] nxt_hold;
  logic              ack_tgl_ff;

  // one word in flight; hold stays still until the link side acknowledges
  assign drain_if.ready = (req_tgl_ff == ack_s2_ff);

  always_comb
  begin
    nxt_req_tgl = req_tgl_ff;
    nxt_hold    = hold_ff;
    if (drain_if.valid && drain_if.ready)
    begin
      nxt_hold    = drain_if.data;
      nxt_req_tgl = !req_tgl_ff;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_tgl_ff <= 1'b0;
      ack_s1_ff  <= 1'b0;
      ack_s2_ff  <= 1'b0;
      hold_ff    <= '0;
    end
    else
    begin
      req_tgl_ff <= nxt_req_tgl;
      ack_s1_ff  <= ack_tgl_ff;
      ack_s2_ff  <= ack_s1_ff;
      hold_ff    <= nxt_hold;
    end
  end

  // ****************************************
  // test clock domain, falling edge
  // ****************************************
  logic                 t_rst1_ff, t_rst_n_ff;
  logic                 req_s1_ff, req_s2_ff;
  logic [WORD_W-1:0]    sreg_ff;
  logic [TDO_CNT_W-1:0] left_ff;
  logic                 tdo_ff, tdo_oe_ff;
  logic                 nxt_ack_tgl, nxt_tdo, nxt_tdo_oe;
  logic [WORD_W-1:0]    nxt_sreg;
  logic [TDO_CNT_W-1:0] nxt_left;

  // reset release is resynchronised so the link side leaves reset cleanly
  always_ff @(negedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t_rst1_ff  <= 1'b0;
      t_rst_n_ff <= 1'b0;
    end
    else
    begin
      t_rst1_ff  <= 1'b1;
      t_rst_n_ff <= t_rst1_ff;
    end
  end

  // a stopped test clock simply stalls the buffer, nothing is lost
  always_comb
  begin
    nxt_ack_tgl = ack_tgl_ff;
    nxt_sreg    = sreg_ff;
    nxt_left    = left_ff;
    nxt_tdo     = tdo_ff;
    nxt_tdo_oe  = 1'b0;
    if ((left_ff == '0) && (req_s2_ff != ack_tgl_ff))
    begin
      nxt_sreg    = hold_ff;
      nxt_left    = TDO_CNT_W'(WORD_W);
      nxt_ack_tgl = !ack_tgl_ff;
    end
    if (tap_shift_state)
    begin
      nxt_tdo_oe = 1'b1;
      if (nxt_left != '0)
      begin
        nxt_tdo  = nxt_sreg[0];
        nxt_sreg = {1'b0, nxt_sreg[WORD_W-1:1]};
        nxt_left = TDO_CNT_W'(nxt_left - 1'b1);
      end
      else
      begin
        nxt_tdo = TDO_IDLE_BIT;
      end
    end
  end

  always_ff @(negedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_s1_ff  <= 1'b0;
      req_s2_ff  <= 1'b0;
      ack_tgl_ff <= 1'b0;
      sreg_ff    <= '0;
      left_ff    <= '0;
      tdo_ff     <= TDO_IDLE_BIT;
      tdo_oe_ff  <= 1'b0;
    end
    else
    begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      if (t_rst_n_ff)
      begin
        ack_tgl_ff <= nxt_ack_tgl;
        sreg_ff    <= nxt_sreg;
        left_ff    <= nxt_left;
        tdo_ff     <= nxt_tdo;
        tdo_oe_ff  <= nxt_tdo_oe;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign quad_pad_out          = q_out_ff;
  assign quad_pad_oe           = q_oe_ff;
  assign quad_pad_pullup_en    = q_pu_ff;
  assign spi_pad_out           = s_out_ff;
  assign spi_pad_oe            = s_oe_ff;
  assign spi_pad_pullup_en     = s_pu_ff;
  assign quad_sel_state        = quad_sel_ff;
  assign spi_sel_state         = spi_sel_ff;
  assign decoder_phase_a_input = dec_ff[0];
  assign decoder_phase_b_input = dec_ff[1];
  assign decoder_index_input   = dec_ff[2];
  assign decoder_home_input    = dec_ff[3];
  assign timer_a_in            = tmr_in_ff;
  assign gpio_c_in             = gc_in_ff;
  assign gpio_e_in             = ge_in_ff;
  assign spi_sclk_in           = sclk_in_ff;
  assign spi_mosi_in           = mosi_in_ff;
  assign spi_miso_in           = miso_in_ff;
  assign spi_selected          = sel_ff;
  assign tdo_wr_ready          = fill_if.ready;
  assign tdo_pad_out           = tdo_ff;
  assign tdo_pad_oe            = tdo_oe_ff;

endmodule

//--- sqtpm_sva.sv
`timescale 1ns/100ps

// ****************************************
// pad mux checker, top ports only
// ****************************************
module sqtpm_sva
  import sqtpm_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 arst_n,
  input wire logic                 tck,
  input wire logic                 tap_shift_state,
  input wire logic                 tdo_pad_oe,
  input wire logic                 spi_master_mode,
  input wire logic                 spi_port0_slave_select_n,
  input wire logic [SPI_PADS-1:0]  spi_sel_state,
  input wire logic [SPI_PADS-1:0]  spi_pad_oe,
  input wire logic                 spi_sel_wr,
  input wire logic                 quad_sel_wr,
  input wire logic [7:0]           quad_sel_data,
  input wire logic [7:0]           quad_sel_state,
  input wire logic [7:0]           port_c_pullup_control,
  input wire logic [7:0]           port_e_pullup_control,
  input wire logic [QUAD_PADS-1:0] quad_pad_pullup_en,
  input wire logic [SPI_PADS-1:0]  spi_pad_pullup_en,
  input wire logic [QUAD_PADS-1:0] quad_pad_oe,
  input wire logic [QUAD_PADS-1:0] gpio_c_dir,
  input wire logic                 spi_sclk_out,
  input wire logic                 spi_mosi_out,
  input wire logic                 spi_miso_out,
  input wire logic [SPI_PADS-1:0]  spi_pad_out
);
  // spi mode held long enough for the select sync and the pad register
  sequence seq_master_held;
    (spi_sel_state == 3'h0 && spi_master_mode) [*2];
  endsequence
  sequence seq_slave_quiet;
    (spi_sel_state == 3'h0 && !spi_master_mode && spi_port0_slave_select_n) [*5];
  endsequence
  sequence seq_slave_chosen;
    (spi_sel_state == 3'h0 && !spi_master_mode && !spi_port0_slave_select_n) [*5];
  endsequence

  a_tdo_float_idle:
    assert property (@(negedge tck) disable iff (!arst_n) !tap_shift_state |=> !tdo_pad_oe)
    else $error("test output driven outside shift");
  a_master_dir:
    assert property (@(posedge core_clk) disable iff (!arst_n) seq_master_held |-> spi_pad_oe == 3'h3)
    else $error("spi master pad directions wrong");
  a_slave_float:
    assert property (@(posedge core_clk) disable iff (!arst_n) seq_slave_quiet |-> spi_pad_oe == 3'h0)
    else $error("unselected slave drives a pad");
  a_slave_drive:
    assert property (@(posedge core_clk) disable iff (!arst_n) seq_slave_chosen |-> spi_pad_oe == 3'h4)
    else $error("selected slave pad directions wrong");
  a_quad_pullup:
    assert property (@(posedge core_clk) disable iff (!arst_n)
      $past(arst_n) |-> quad_pad_pullup_en == $past(port_c_pullup_control[7:4]))
    else $error("decoder pull-up enables wrong");
  a_spi_pullup:
    assert property (@(posedge core_clk) disable iff (!arst_n)
      $past(arst_n) |-> spi_pad_pullup_en == $past(port_e_pullup_control[6:4]))
    else $error("spi pull-up enables wrong");
  a_quad_sel_load:
    assert property (@(posedge core_clk) disable iff (!arst_n)
      quad_sel_wr |=> quad_sel_state == $past(quad_sel_data))
    else $error("selector did not load");
  a_sel_hold:
    assert property (@(posedge core_clk) disable iff (!arst_n)
      !quad_sel_wr && !spi_sel_wr |=> $stable(quad_sel_state) && $stable(spi_sel_state))
    else $error("selector changed without a write");
  a_dec_inputs:
    assert property (@(posedge core_clk) disable iff (!arst_n)
      (quad_sel_state == QUAD_SEL_RESET) [*2] |-> quad_pad_oe == 4'h0)
    else $error("decoder pad driven");
  a_gpio_c_dir:
    assert property (@(posedge core_clk) disable iff (!arst_n)
      (quad_sel_state[1:0] == QUAD_FUNC_GPIO) [*2] |-> quad_pad_oe[0] == $past(gpio_c_dir[0]))
    else $error("gpio pad direction not followed");
  // clock and data share one register stage, so the core's half-cycle lead survives
  a_spi_phase_kept:
    assert property (@(posedge core_clk) disable iff (!arst_n)
      spi_sel_state == 3'h0
      |=> spi_pad_out == $past({spi_miso_out, spi_mosi_out, spi_sclk_out}))
    else $error("spi pad data lost its phase to the clock");
endmodule

//--- sqtpm_peer.sv
`timescale 1ns/100ps

// ****************************************
// far side: test host clock, encoder, spi peer
// ****************************************
module sqtpm_peer
(
  input  wire logic       run_frame,
  input  wire logic [3:0] enc_level,
  input  wire logic [3:0] quad_out,
  input  wire logic [3:0] quad_oe,
  input  wire logic [2:0] peer_val,
  input  wire logic [2:0] peer_en,
  input  wire logic [2:0] spi_out,
  input  wire logic [2:0] spi_oe,
  output logic            tck,
  output wire logic [3:0] quad_in,
  output wire logic [2:0] spi_in
);
  // test clock toggles only inside frames; pin is driven low between them
  initial
  begin
    tck = 1'b0;
    #3.7;
    forever
    begin
      #6;
      tck = run_frame ? ~tck : 1'b0;
    end
  end
  // encoder always drives; device drive wins where enabled
  assign quad_in = (quad_oe & quad_out) | (~quad_oe & enc_level);
  // released lines fall to the pull-up, never keep a stale value
  assign spi_in = (spi_oe & spi_out) | (~spi_oe & (~peer_en | peer_val));
endmodule

//--- testbench.sv
`timescale 1ns/100ps

module testbench
  import sqtpm_pkg::*;
;
  logic       core_clk, arst_n, tck, spi_port0_slave_select_n, quad_sel_wr, spi_sel_wr;
  logic       spi_master_mode, spi_sclk_out, spi_mosi_out, spi_miso_out, tap_shift_state;
  logic       tdo_wr_valid, tdo_wr_ready, tdo_pad_out, tdo_pad_oe, spi_selected, run_frame;
  logic       decoder_phase_a_input, decoder_phase_b_input, decoder_index_input;
  logic       decoder_home_input, spi_sclk_in, spi_mosi_in, spi_miso_in;
  logic [3:0] quad_pad_in, quad_pad_out, quad_pad_oe, quad_pad_pullup_en, timer_a_out;
  logic [3:0] timer_a_oe, timer_a_in, gpio_c_out, gpio_c_dir, gpio_c_in, enc_level;
  logic [2:0] spi_pad_in, spi_pad_out, spi_pad_oe, spi_pad_pullup_en, spi_sel_data;
  logic [2:0] spi_sel_state, gpio_e_out, gpio_e_dir, gpio_e_in, peer_val, peer_en;
  logic [7:0] port_c_pullup_control, port_e_pullup_control, quad_sel_data, quad_sel_state;
  logic [7:0] tdo_wr_data;
  logic [7:0] words[$];
  int         fails, n_compared, cycles;

  sqtpm_pad_mux dut_u (.*);
  sqtpm_peer peer_u (.run_frame(run_frame), .enc_level(enc_level), .quad_out(quad_pad_out),
    .quad_oe(quad_pad_oe), .peer_val(peer_val), .peer_en(peer_en), .spi_out(spi_pad_out),
    .spi_oe(spi_pad_oe), .tck(tck), .quad_in(quad_pad_in), .spi_in(spi_pad_in));

  // ****************************************
  // clock, timeout, shared tasks
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // run needs about a hundred cycles; ceiling leaves ample slack
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr_sel(input logic [7:0] q, input logic [2:0] s);
    quad_sel_data = q;
    spi_sel_data = s;
    {quad_sel_wr, spi_sel_wr} = 2'b11;
    cyc(1);
    {quad_sel_wr, spi_sel_wr} = 2'b00;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk({quad_sel_state, spi_sel_state}, 11'h000);
    chk({quad_pad_oe, spi_pad_oe}, 7'h03);
    chk({quad_pad_pullup_en, spi_pad_pullup_en, tdo_pad_oe}, 8'hFE);
    chk({decoder_home_input, decoder_index_input, decoder_phase_b_input,
      decoder_phase_a_input}, enc_level);
  endtask
  task automatic t_pullup;
    for (int i = 0; i < 2; i++)
    begin
      port_c_pullup_control = i ? 8'hA5 : 8'h5A;
      port_e_pullup_control = ~port_c_pullup_control;
      cyc(2);
      chk(quad_pad_pullup_en, port_c_pullup_control[7:4]);
      chk(spi_pad_pullup_en, port_e_pullup_control[6:4]);
    end
  endtask
  // pad0 gpio, pad1 timer, pad2 gpio, pad3 decoder
  task automatic t_quad;
    {timer_a_oe, timer_a_out, gpio_c_dir, gpio_c_out} = 16'hF2_11;
    enc_level = 4'h4;
    wr_sel(8'h26, 3'h0);
    cyc(6);
    chk({quad_pad_oe, quad_pad_out & quad_pad_oe}, 8'h33);
    chk({gpio_c_in, timer_a_in}, 8'h52);
    chk({decoder_home_input, decoder_phase_a_input}, {1'b0, DEC_IDLE_LEVEL});
    gpio_c_dir = 4'h4;
    cyc(2);
    chk(quad_pad_oe, 4'h6);
    // code 3 falls back to the decoder as well
    wr_sel(8'hFF, 3'h0);
    cyc(2);
    chk({quad_pad_oe, decoder_phase_a_input}, 5'h00);
  endtask
  task automatic t_spi;
    {spi_sclk_out, spi_mosi_out, spi_miso_out, peer_en, peer_val} = 9'b101_100_100;
    cyc(4);
    chk({spi_pad_oe, spi_pad_out[1:0], spi_miso_in}, 6'b011_01_1);
    spi_master_mode = 1'b0;
    {peer_en, peer_val} = 6'b011_010;
    cyc(5);
    chk({spi_pad_oe, spi_mosi_in, spi_sclk_in}, 5'b000_10);
    spi_port0_slave_select_n = 1'b0;
    cyc(5);
    chk({spi_selected, spi_pad_oe, spi_pad_out[2]}, 5'b1_100_1);
    {spi_port0_slave_select_n, spi_master_mode} = 2'b11;
    cyc(5);
  endtask
  task automatic t_spi_gpio;
    {gpio_e_dir, gpio_e_out, peer_en, peer_val} = 12'b001_001_100_000;
    {spi_sclk_out, spi_mosi_out} = 2'b01;
    wr_sel(8'h00, 3'h5);
    cyc(4);
    chk({spi_pad_oe, spi_pad_out[1:0], gpio_e_in}, 8'b011_11_001);
    wr_sel(8'h00, 3'h0);
  endtask
  // fill the buffer with the link stopped, then shift the first word out
  task automatic t_tdo;
    for (int k = 0; k < 12; k++)
    begin
      tdo_wr_valid = 1'b1;
      tdo_wr_data = 8'hA5 ^ 8'(k);
      if (tdo_wr_ready)
        words.push_back(tdo_wr_data);
      cyc(1);
    end
    tdo_wr_valid = 1'b0;
    chk({tdo_wr_ready, words.size() >= 8}, 2'b01); // buffer refuses when full
    run_frame = 1'b1;
    repeat (8) @(negedge tck);
    @(posedge tck);
    tap_shift_state = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge tck);
      #1;
      chk({tdo_pad_oe, tdo_pad_out}, {1'b1, words[0][i]});
      @(posedge tck);
      chk(tdo_pad_out, words[0][i]);
    end
    tap_shift_state = 1'b0;
    @(negedge tck);
    #1;
    chk(tdo_pad_oe, 1'b0);
    run_frame = 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {arst_n, quad_sel_wr, spi_sel_wr, tdo_wr_valid, tap_shift_state} = '0;
    {spi_master_mode, spi_sclk_out, spi_mosi_out, spi_miso_out} = 4'h8;
    {quad_sel_data, spi_sel_data, tdo_wr_data, peer_val, peer_en} = '0;
    {timer_a_out, timer_a_oe, gpio_c_out, gpio_c_dir, gpio_e_out, gpio_e_dir} = '0;
    {port_c_pullup_control, port_e_pullup_control} = 16'hFFFF;
    {spi_port0_slave_select_n, run_frame, enc_level} = 6'b11_0101;
    {fails, n_compared, cycles} = '0;
    // test clock runs during reset so its side resets too
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    run_frame = 1'b0;
    cyc(4);
    t_reset();
    t_pullup();
    t_quad();
    t_spi();
    t_spi_gpio();
    t_tdo();
    conclude();
  end
endmodule

bind sqtpm_pad_mux sqtpm_sva chk_u (.*);
